// ===== rtl/iaba_adapter.sv
// interrupt-acknowledge adapter between a two-pulse host and a chained bus
//
// Overview of operation
// RULE1: in an acknowledge cycle the data strobe falls only after the chain has had time to settle.
// RULE2: the needed delay is the first-device value plus the last-device value plus a middle value per device between.
// RULE3: for the fast grade the first value is 250 ns and the middle value 100 ns, used in the budget.
// RULE4: the host runs two identical acknowledge cycles two idle clocks apart, with read and write idle.
// RULE5: the acknowledge level toggles on each rising edge of the host acknowledge strobe.
// RULE6: in the second acknowledge cycle the host is held in wait, the data strobe falls after settling, then the wait ends.
// RULE7: with the acknowledge level inactive, the wait count is chosen by the selected tap.
// RULE8: with the level active, ones shift in; the seventh tap lowers the data strobe, the eighth ends the wait.
// RULE9: the full register gives a settling interval above 1300 ns, enough for seven devices.
// RULE10: an optional system reset forces address and data strobes low together.
// RULE11: every peripheral edge is derived from the host strobes, not from any peripheral clock.
// RULE12: peripherals latch the acknowledge level on the address strobe rising edge.
// RULE13: a pending or in-service source holds its chain enable out low; the model has no in-service state and gates the chain on pending only.
// RULE14: the host waits as long as its ready request is low.
// RULE15: the shift register is held clear whenever no host strobe is active.
`timescale 1ns/100ps
`default_nettype none
`include "iaba_regs.svh"

module iaba_adapter
  import iaba_pkg::*;
(
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // host pins
  input  wire iaba_host_t             host_pins,
  input  wire logic                   sys_reset,
  // configuration
  input  wire logic                   hw_reset_en,
  input  wire logic [2:0]             wait_tap_sel,
  // peripheral strobes
  output iaba_periph_t                periph_pins,
  // host wait control
  output logic                        host_ready_request
);

  // ==========================================================
  // derived cycle counts, see RULE2, RULE3 and RULE9
  localparam int SETTLE_CYC = `IABA_SETTLE_NS / `IABA_CLK_NS + 1;
  localparam int STEP_CYC   = (SETTLE_CYC + `IABA_TAP_DATA)
                            / (`IABA_TAP_DATA + 1);
  localparam int CHAIN_NS   = `IABA_T_FIRST_NS
                            + (`IABA_CHAIN_MAX - 2) * `IABA_T_MID_NS
                            + `IABA_T_LAST_NS;
  localparam logic [`IABA_DIV_W-1:0] STEP_LAST =
    `IABA_DIV_W'(STEP_CYC - 1);

  // ==========================================================
  // pin synchronisers, a change counts once stages two and three agree
  logic [`IABA_PIN_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
  logic [`IABA_PIN_W-1:0] pins_raw;

  assign pins_raw = {sys_reset, host_pins.ale, host_pins.ack_n,
                     host_pins.wr_n, host_pins.rd_n};

  always_comb begin
    filt_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_q   <= `IABA_PIN_RST;
      s2_q   <= `IABA_PIN_RST;
      s3_q   <= `IABA_PIN_RST;
      filt_q <= `IABA_PIN_RST;
    end else begin
      s1_q   <= pins_raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  logic rd_act, wr_act, ack_act, ale_f, sysrst_f;
  assign rd_act   = !filt_q[`IABA_PIN_RD];
  assign wr_act   = !filt_q[`IABA_PIN_WR];
  assign ack_act  = !filt_q[`IABA_PIN_ACK];
  assign ale_f    = filt_q[`IABA_PIN_ALE];
  assign sysrst_f = filt_q[`IABA_PIN_SYSRST];

  // ==========================================================
  // acknowledge level toggle and step divider
  logic                   ack_prev_q, ack_prev_d;
  logic                   ack_lvl_n_q, ack_lvl_n_d;
  logic [`IABA_DIV_W-1:0] div_q, div_d;
  logic                   strobe_act, ack_rise, shift_en;
  logic [`IABA_SR_W-1:0]  taps;

  assign strobe_act = rd_act | wr_act | ack_act;
  assign ack_rise   = ack_prev_q & !ack_act;
  assign shift_en   = strobe_act && (div_q == STEP_LAST);

  always_comb begin
    ack_prev_d  = ack_act;
    ack_lvl_n_d = ack_lvl_n_q;
    if (ack_rise) begin
      ack_lvl_n_d = !ack_lvl_n_q;  // see RULE5
    end
    if (!strobe_act || div_q == STEP_LAST) begin
      div_d = `IABA_DIV_RST;
    end else begin
      div_d = div_q + `IABA_DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack_prev_q  <= 1'b0;
      ack_lvl_n_q <= 1'b1;
      div_q       <= `IABA_DIV_RST;
    end else begin
      ack_prev_q  <= ack_prev_d;
      ack_lvl_n_q <= ack_lvl_n_d;
      div_q       <= div_d;
    end
  end

  // held clear while no host strobe is active, see RULE15
  iaba_shift_reg u_sr (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clear    (!strobe_act),
    .shift_en (shift_en),
    .taps     (taps)
  );

  // ==========================================================
  // output strobes, all timing taken from host strobes (see RULE11)
  iaba_periph_t periph_d;
  logic         ready_d;
  logic         force_rst;
  logic         ack_mode;

  assign force_rst = hw_reset_en & sysrst_f;
  assign ack_mode  = !ack_lvl_n_q;

  always_comb begin
    periph_d.periph_ack_level_n = ack_lvl_n_q;
    periph_d.address_strobe_n   = !ale_f;
    // data strobe waits for the settling taps, see RULE1 and RULE8
    periph_d.data_strobe_n      = !(ack_mode && ack_act &&
                                    taps[`IABA_TAP_DATA]);
    if (force_rst) begin
      periph_d.address_strobe_n = 1'b0;  // see RULE10
      periph_d.data_strobe_n    = 1'b0;
    end
    if (!strobe_act) begin
      ready_d = 1'b1;
    end else if (ack_mode && ack_act) begin
      ready_d = taps[`IABA_TAP_RDY];  // see RULE6
    end else begin
      ready_d = taps[wait_tap_sel];  // see RULE7
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      periph_pins        <= '1;
      host_ready_request <= 1'b1;
    end else begin
      periph_pins        <= periph_d;
      host_ready_request <= ready_d;
    end
  end

  // ==========================================================
  // checks
  logic [`IABA_CNT_W-1:0] settle_cnt_q, settle_cnt_d;

  always_comb begin
    if (!ack_act) begin
      settle_cnt_d = '0;
    end else if (settle_cnt_q == `IABA_CNT_MAX) begin
      settle_cnt_d = settle_cnt_q;
    end else begin
      settle_cnt_d = settle_cnt_q + `IABA_CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      settle_cnt_q <= '0;
    end else begin
      settle_cnt_q <= settle_cnt_d;
    end
  end

  localparam int SETTLE_MIN = SETTLE_CYC;

  sequence s_data_fall;
    $fell(periph_pins.data_strobe_n) && !force_rst;
  endsequence

  // ready rises one edge after the last tap has been seen
  sequence s_ready_rise;
    ##1 $rose(host_ready_request);
  endsequence

  property p_ack_toggle;
    @(posedge core_clk) disable iff (!rst_n)
      ack_rise |=> ##1 (periph_pins.periph_ack_level_n
                        != $past(periph_pins.periph_ack_level_n));
  endproperty
  a_ack_toggle: assert property (p_ack_toggle)  // see RULE5
    else $error("ack level did not toggle");

  property p_data_only_ack;
    @(posedge core_clk) disable iff (!rst_n)
      s_data_fall |-> !periph_pins.periph_ack_level_n;
  endproperty
  a_data_only_ack: assert property (p_data_only_ack)  // see RULE1
    else $error("data strobe outside acknowledge");

  property p_settle;
    @(posedge core_clk) disable iff (!rst_n)
      s_data_fall |-> settle_cnt_q >= SETTLE_MIN;
  endproperty
  a_settle: assert property (p_settle)  // see RULE9
    else $error("settling interval too short");

  property p_release;
    @(posedge core_clk) disable iff (!rst_n)
      s_data_fall ##1 ack_act [*3] |-> s_ready_rise;
  endproperty
  a_release: assert property (p_release)  // see RULE8
    else $error("wait not ended after data strobe");

  property p_wait_held;
    @(posedge core_clk) disable iff (!rst_n)
      (ack_mode && ack_act && !taps[`IABA_TAP_RDY]) |=> !host_ready_request;
  endproperty
  a_wait_held: assert property (p_wait_held)  // see RULE6
    else $error("host released too early");

  property p_clear_idle;
    @(posedge core_clk) disable iff (!rst_n)
      !strobe_act |=> (taps == `IABA_SR_CLR) && host_ready_request;
  endproperty
  a_clear_idle: assert property (p_clear_idle)  // see RULE15
    else $error("shift register not cleared");

  property p_normal_wait;
    @(posedge core_clk) disable iff (!rst_n)
      ($rose(strobe_act) && !ack_mode && wait_tap_sel != 3'h0)
        |=> ##1 !host_ready_request;
  endproperty
  a_normal_wait: assert property (p_normal_wait)  // see RULE7
    else $error("no wait state on normal access");

  property p_hw_reset;
    @(posedge core_clk) disable iff (!rst_n)
      force_rst |=> !periph_pins.address_strobe_n
                    && !periph_pins.data_strobe_n;
  endproperty
  a_hw_reset: assert property (p_hw_reset)  // see RULE10
    else $error("strobes not forced low");

  property p_budget;
    @(posedge core_clk) disable iff (!rst_n)
      s_data_fall |-> (settle_cnt_q * `IABA_CLK_NS > CHAIN_NS)
                      && (STEP_CYC * (`IABA_TAP_DATA + 1) >= SETTLE_CYC);
  endproperty
  a_budget: assert property (p_budget)  // see RULE2 and RULE3
    else $error("chain budget exceeds settling");

endmodule
`default_nettype wire

// ===== rtl/iaba_pkg.sv
// types of the interrupt-acknowledge bus adapter
package iaba_pkg;

  // ==========================================================
  // host side pins, strobes active low except the latch enable
  typedef struct packed {
    logic ale;
    logic ack_n;
    logic wr_n;
    logic rd_n;
  } iaba_host_t;

  // ==========================================================
  // peripheral side strobes, all active low
  typedef struct packed {
    logic address_strobe_n;
    logic data_strobe_n;
    logic periph_ack_level_n;
  } iaba_periph_t;

endpackage

// ===== rtl/iaba_regs.svh
// constants of the interrupt-acknowledge bus adapter
`ifndef IABA_REGS_SVH
`define IABA_REGS_SVH

// ==========================================================
// clock and settling times
`define IABA_CLK_NS       50
`define IABA_SETTLE_NS    1300
`define IABA_T_FIRST_NS   250
`define IABA_T_MID_NS     100
`define IABA_T_LAST_NS    100
`define IABA_CHAIN_MAX    7

// ==========================================================
// shift register layout
`define IABA_SR_W         8
`define IABA_SR_CLR       8'h00
`define IABA_TAP_DATA     3'h6
`define IABA_TAP_RDY      3'h7
`define IABA_DIV_W        4
`define IABA_DIV_RST      4'h0

// ==========================================================
// pin vector layout {sys_reset, ale, ack_n, wr_n, rd_n}
`define IABA_PIN_W        5
`define IABA_PIN_RST      5'h07
`define IABA_PIN_RD       0
`define IABA_PIN_WR       1
`define IABA_PIN_ACK      2
`define IABA_PIN_ALE      3
`define IABA_PIN_SYSRST   4
`define IABA_CNT_W        8
`define IABA_CNT_MAX      8'hff

`endif

// ===== rtl/iaba_shift_reg.sv
// wait-state shift register: ones shift in from tap 0 while enabled
`timescale 1ns/100ps
`default_nettype none
`include "iaba_regs.svh"

module iaba_shift_reg (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // control
  input  wire logic                   clear,
  input  wire logic                   shift_en,
  // taps
  output logic [`IABA_SR_W-1:0]       taps
);

  logic [`IABA_SR_W-1:0] taps_d;

  always_comb begin
    if (clear) begin
      taps_d = `IABA_SR_CLR;
    end else if (shift_en) begin
      taps_d = {taps[`IABA_SR_W-2:0], 1'b1};
    end else begin
      taps_d = taps;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      taps <= `IABA_SR_CLR;
    end else begin
      taps <= taps_d;
    end
  end

endmodule
`default_nettype wire

// ===== sim/iaba_periph_model.sv
// behavioural model of the chained peripherals behind the adapter
`timescale 1ns/100ps
`default_nettype none

module iaba_periph_model
  import iaba_pkg::*;
(
  // strobes from the adapter, no peripheral clock needed
  input  wire iaba_periph_t periph_pins,
  // pending requests, index 0 has the highest priority
  input  wire logic [2:0]   pending,
  // observed results
  output logic              ack_cycle,
  output logic              vec_ok,
  output logic [2:0]        vec
);
  logic [3:0] chain_enable_in;

  // =========================================================
  // cycle kind latched as the address strobe rises
  always @(posedge periph_pins.address_strobe_n) begin
    ack_cycle <= !periph_pins.periph_ack_level_n;
  end

  // =========================================================
  // priority chain and vector drive
  always_comb begin
    chain_enable_in[0] = 1'b1;
    for (int i = 0; i < 3; i++) begin
      chain_enable_in[i+1] = chain_enable_in[i] & !pending[i];
    end
    vec_ok = ack_cycle & !periph_pins.data_strobe_n;
    vec    = 3'h7;
    for (int i = 2; i >= 0; i--) begin
      if (vec_ok && chain_enable_in[i] && pending[i]) begin
        vec = 3'(i);
      end
    end
    // released bus floats to the pull-up level
    if (!vec_ok) begin
      vec = 3'h7;
    end
  end
endmodule

`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench of the interrupt-acknowledge adapter
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import iaba_pkg::*;
  logic         core_clk;
  logic         rst_n;
  logic         sys_reset;
  logic         hw_reset_en;
  logic [2:0]   wait_tap_sel;
  logic [2:0]   pending;
  iaba_host_t   hp;
  iaba_periph_t pp;
  logic         rdy;
  logic         ack_cycle;
  logic         vec_ok;
  logic [2:0]   vec;
  logic [7:0]   vgot;
  logic [9:0]   rows [8];
  int           failures;
  int           n_tests;
  int           lo;
  int           dsat;
  int           k;

  iaba_adapter iaba_adapter_inst (
    .core_clk           (core_clk),
    .rst_n              (rst_n),
    .host_pins          (hp),
    .sys_reset          (sys_reset),
    .hw_reset_en        (hw_reset_en),
    .wait_tap_sel       (wait_tap_sel),
    .periph_pins        (pp),
    .host_ready_request (rdy)
  );

  iaba_periph_model iaba_periph_model_inst (
    .periph_pins (pp),
    .pending     (pending),
    .ack_cycle   (ack_cycle),
    .vec_ok      (vec_ok),
    .vec         (vec)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic conclude();
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one host strobe, counting cycles with ready held low
  task automatic strobe(input int b);
    hp[b] = 1'b0;
    for (k = 0; k < 100 && rdy !== 1'b0; k++) @(negedge core_clk);
    if (k >= 100) begin
      failures++;
      conclude();
    end
    lo   = 0;
    dsat = -1;
    vgot = 8'h00;
    while (rdy === 1'b0 && lo < 100) begin
      if (pp.data_strobe_n === 1'b0 && dsat < 0) begin
        dsat = lo;
        vgot = 8'({vec_ok, vec});
      end
      lo++;
      @(negedge core_clk);
    end
    if (lo >= 100) begin
      failures++;
      conclude();
    end
    hp[b] = 1'b1;
    repeat (10) @(negedge core_clk);
  endtask

  task automatic ale_pulse();
    hp.ale = 1'b1;
    repeat (2) @(negedge core_clk);
    hp.ale = 1'b0;
    repeat (8) @(negedge core_clk);
  endtask

  initial begin
    rst_n        = 1'b0;
    sys_reset    = 1'b0;
    hw_reset_en  = 1'b0;
    wait_tap_sel = 3'h0;
    pending      = 3'h6;
    hp           = 4'h7;
    failures     = 0;
    n_tests      = 0;
    // rows: {tap select, write strobe, wait cycles}
    rows = '{10'h004, 10'h0c8, 10'h10c, 10'h1d0,
             10'h214, 10'h2d8, 10'h31c, 10'h3e0};
    repeat (20) @(negedge core_clk);
    chk(8'({pp, rdy}), 8'h0f);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    foreach (rows[i]) begin
      wait_tap_sel = rows[i][9:7];
      strobe(rows[i][6] ? 1 : 0);
      chk(8'(lo), 8'(rows[i][5:0]));
    end
    // =======================================================
    // two-pulse acknowledge sequence
    wait_tap_sel = 3'h1;
    ale_pulse();
    strobe(2);
    chk(8'(lo), 8'h08);
    chk(8'(ack_cycle), 8'h00);
    chk(8'(pp.periph_ack_level_n), 8'h00);
    ale_pulse();
    chk(8'(ack_cycle), 8'h01);
    strobe(2);
    chk(8'(lo), 8'h20);
    chk(8'(dsat), 8'h1c);
    chk(vgot, 8'h09);
    chk(8'(pp.periph_ack_level_n), 8'h01);
    // =======================================================
    // hardware reset path, disabled then enabled
    sys_reset = 1'b1;
    repeat (8) @(negedge core_clk);
    chk(8'({pp.address_strobe_n, pp.data_strobe_n}), 8'h03);
    hw_reset_en = 1'b1;
    repeat (8) @(negedge core_clk);
    chk(8'({pp.address_strobe_n, pp.data_strobe_n}), 8'h00);
    sys_reset = 1'b0;
    repeat (8) @(negedge core_clk);
    chk(8'({pp.address_strobe_n, pp.data_strobe_n}), 8'h03);
    conclude();
  end
endmodule

`default_nettype wire
